/* File: core/lrc_pkg.sv */
// shared constants for the linear regulator control register bank
package lrc_pkg;
	// register indices; the apb byte address is four times the index
	localparam logic [7:0] LRC_IDX_REG_TWO = 8'h27;
	localparam logic [7:0] LRC_IDX_REG_THREE = 8'h28;
	localparam logic [7:0] LRC_IDX_REG_FOUR = 8'h29;
	localparam logic [2:0][7:0] LRC_IDX_ALL = {LRC_IDX_REG_FOUR,
		LRC_IDX_REG_THREE, LRC_IDX_REG_TWO};
	localparam int LRC_NUM_REG = 3;
	// field positions inside each control register
	localparam int LRC_BIT_ON = 0;
	localparam int LRC_FLD_EN_SEL = 1;
	localparam int LRC_BIT_PD_OFF = 3;
	localparam int LRC_BIT_RSVD = 4;
	localparam int LRC_FLD_V_SEL = 5;
	localparam int LRC_BIT_SEQ = 7;
	// pin select codes
	localparam logic [1:0] LRC_SEL_SEQ = 2'h0;
	localparam logic [1:0] LRC_SEL_PIN_FIRST = 2'h1;
	localparam logic [1:0] LRC_SEL_PIN_SECOND = 2'h2;
	localparam logic [1:0] LRC_SEL_PIN_THIRTEENTH = 2'h3;
	// reset value of every control register
	localparam logic [7:0] LRC_CTRL_RESET = 8'h00;
	localparam logic [31:0] LRC_RDATA_IDLE = 32'h0000_0000;
endpackage : lrc_pkg

/* File: core/lrc_reg_chan.sv */
// one regulator control register with its pin and sequencer logic
`timescale 1ns/1ps
`default_nettype none
module lrc_reg_chan (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register write side
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// pin edges and sequencer
	input wire logic [2:0] pin_rise,
	input wire logic [2:0] pin_fall,
	input wire logic seq_apply,
	input wire logic seq_target_second,
	// state
	output logic [7:0] ctrl_q,
	output logic pulldown_on_q,
	output logic target_second_q,
	output logic ramp_start_q
);
	logic [7:0] ctrl_d;
	logic pulldown_on_d;
	logic target_second_d;
	logic ramp_start_d;
	logic [1:0] en_sel;
	logic [1:0] v_sel;
	logic [1:0] en_pin;
	logic [1:0] v_pin;

	assign en_sel = ctrl_q[lrc_pkg::LRC_FLD_EN_SEL +: 2];
	assign v_sel = ctrl_q[lrc_pkg::LRC_FLD_V_SEL +: 2];
	assign en_pin = en_sel - 2'h1;
	assign v_pin = v_sel - 2'h1;

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_en) begin
			ctrl_d = wr_data; // R8
		end
		// hardware updates of the on bit win over a same-cycle write
		if (en_sel == lrc_pkg::LRC_SEL_SEQ) begin // R4
			if (seq_apply) begin
				ctrl_d[lrc_pkg::LRC_BIT_ON] = ctrl_q[lrc_pkg::LRC_BIT_SEQ]; // R3
			end
		end else if (pin_rise[en_pin]) begin
			ctrl_d[lrc_pkg::LRC_BIT_ON] = 1'b1; // R5
		end else if (pin_fall[en_pin]) begin
			ctrl_d[lrc_pkg::LRC_BIT_ON] = 1'b0; // R5
		end
		target_second_d = target_second_q;
		if (v_sel == lrc_pkg::LRC_SEL_SEQ) begin // R7
			if (seq_apply) begin
				target_second_d = seq_target_second;
			end
		end else if (pin_rise[v_pin]) begin
			target_second_d = 1'b0; // R6
		end else if (pin_fall[v_pin]) begin
			target_second_d = 1'b1; // R6
		end
		// a target change starts a ramp in the analog stage
		ramp_start_d = target_second_d != target_second_q; // R6
		// discharge only while off and not disabled by software
		pulldown_on_d = !ctrl_d[lrc_pkg::LRC_BIT_ON]
			&& !ctrl_d[lrc_pkg::LRC_BIT_PD_OFF]; // R2
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= lrc_pkg::LRC_CTRL_RESET;
			pulldown_on_q <= !lrc_pkg::LRC_CTRL_RESET[lrc_pkg::LRC_BIT_PD_OFF];
			target_second_q <= 1'b0;
			ramp_start_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d; // R1
			pulldown_on_q <= pulldown_on_d;
			target_second_q <= target_second_d;
			ramp_start_q <= ramp_start_d;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_pin_on;
		en_sel != lrc_pkg::LRC_SEL_SEQ && pin_rise[en_pin];
	endsequence
	sequence s_pin_off;
		en_sel != lrc_pkg::LRC_SEL_SEQ && !pin_rise[en_pin]
			&& pin_fall[en_pin];
	endsequence

	chk_pin_turns_on: assert property (s_pin_on |=> ctrl_q[0]) // R5
		else $error("pin rise did not switch regulator on");
	chk_pin_turns_off: assert property (s_pin_off |=> !ctrl_q[0]) // R5
		else $error("pin fall did not switch regulator off");
	chk_seq_applies: assert property (en_sel == 2'h0 && seq_apply // R3
		|=> ctrl_q[0] == $past(ctrl_q[7]))
		else $error("sequencer target not applied to on bit");
	chk_seq_ignores_pins: assert property (en_sel == 2'h0 && !seq_apply // R4
		&& !wr_en |=> $stable(ctrl_q[0]))
		else $error("on bit moved under sequencer control");
	chk_write_sets_on: assert property (wr_en && en_sel == 2'h0 // R1
		&& !seq_apply |=> ctrl_q[0] == $past(wr_data[0]))
		else $error("write did not set the on bit");
	chk_pulldown_level: assert property (##1 pulldown_on_q // R2
		== (!ctrl_q[0] && !ctrl_q[3]))
		else $error("pull-down does not follow on and disable bits");
	chk_volt_first: assert property (v_sel != 2'h0 && pin_rise[v_pin] // R6
		|=> !target_second_q)
		else $error("pin rise did not select first target");
	chk_volt_second: assert property (v_sel != 2'h0 && !pin_rise[v_pin] // R6
		&& pin_fall[v_pin] |=> target_second_q ##1 !ramp_start_q)
		else $error("pin fall did not select second target");
	chk_volt_seq_only: assert property (v_sel == 2'h0 && !seq_apply // R7
		|=> $stable(target_second_q))
		else $error("target moved without sequencer under code 00");
endmodule : lrc_reg_chan
`default_nettype wire

/* File: core/lrc_regs.sv */
// apb register bank for the second, third and fourth linear regulators
//
// Summary of operation
// R1: bit 0 switches the regulator off when clear, on when set.
// R2: bit 3 clear enables output discharge pull-down while off.
// R3: bit 7 is the on value the sequencer applies in its run.
// R4: bits 2:1 pick on/off source: sequencer, first, second, thirteenth pin.
// R5: selected pin rising switches regulator on, falling switches it off.
// R6: bits 6:5 pin rise picks first target, fall second, with ramp.
// R7: voltage select codes: 00 sequencer, 01/10/11 first/second/thirteenth pin.
// R8: bit 4 is stored and read back but changes no behaviour.
`timescale 1ns/1ps
`default_nettype none
module lrc_regs #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// general purpose inputs, active high
	input wire logic gpio_first,
	input wire logic gpio_second,
	input wire logic gpio_thirteenth,
	// power sequencer
	input wire logic seq_apply,
	input wire logic [2:0] seq_target_second,
	// second regulator
	output logic reg_two_on,
	output logic reg_two_pulldown_on,
	output logic reg_two_target_second,
	output logic reg_two_ramp_start,
	// third regulator
	output logic reg_three_on,
	output logic reg_three_pulldown_on,
	output logic reg_three_target_second,
	output logic reg_three_ramp_start,
	// fourth regulator
	output logic reg_four_on,
	output logic reg_four_pulldown_on,
	output logic reg_four_target_second,
	output logic reg_four_ramp_start
);
	localparam int N = lrc_pkg::LRC_NUM_REG;

	logic [2:0] pins;
	logic [2:0] pins_q;
	logic [2:0] pins_d;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic [N-1:0] hit;
	logic [N-1:0] wr_en;
	logic [N-1:0][7:0] ctrl;
	logic [N-1:0] pulldown_on;
	logic [N-1:0] target_second;
	logic [N-1:0] ramp_start;
	logic setup;
	logic access;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;

	assign pins = {gpio_thirteenth, gpio_second, gpio_first};
	assign pins_d = pins;
	// edges are seen against the previous sample, shared by all channels
	// so that changing a select field never fakes an edge
	assign pin_rise = pins & ~pins_q;
	assign pin_fall = ~pins & pins_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			pins_q <= 3'h0;
		end else begin
			pins_q <= pins_d;
		end
	end

	assign setup = psel && !penable;
	assign access = psel && penable;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_chan
			assign hit[i] = paddr
				== ADDR_W'({lrc_pkg::LRC_IDX_ALL[i], 2'b00});
			// only byte lane 0 carries register bits
			assign wr_en[i] = access && pwrite && hit[i] && pstrb[0];

			lrc_reg_chan u_chan (
				.clock(clock),
				.rst(rst),
				.wr_en(wr_en[i]),
				.wr_data(pwdata[7:0]),
				.pin_rise(pin_rise),
				.pin_fall(pin_fall),
				.seq_apply(seq_apply),
				.seq_target_second(seq_target_second[i]),
				.ctrl_q(ctrl[i]),
				.pulldown_on_q(pulldown_on[i]),
				.target_second_q(target_second[i]),
				.ramp_start_q(ramp_start[i])
			);
		end
	endgenerate

	// read data is captured in the setup phase so the slave never waits;
	// the on bit may move by one cycle before the master samples it
	always_comb begin
		prdata_d = prdata_q;
		if (setup && !pwrite) begin
			prdata_d = lrc_pkg::LRC_RDATA_IDLE;
			for (int k = 0; k < N; k++) begin
				if (hit[k]) begin
					prdata_d = {24'h00_0000, ctrl[k]}; // R8
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prdata_q <= lrc_pkg::LRC_RDATA_IDLE;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access && (hit == '0);

	assign reg_two_on = ctrl[0][lrc_pkg::LRC_BIT_ON]; // R1
	assign reg_three_on = ctrl[1][lrc_pkg::LRC_BIT_ON]; // R1
	assign reg_four_on = ctrl[2][lrc_pkg::LRC_BIT_ON]; // R1
	assign reg_two_pulldown_on = pulldown_on[0];
	assign reg_three_pulldown_on = pulldown_on[1];
	assign reg_four_pulldown_on = pulldown_on[2];
	assign reg_two_target_second = target_second[0];
	assign reg_three_target_second = target_second[1];
	assign reg_four_target_second = target_second[2];
	assign reg_two_ramp_start = ramp_start[0];
	assign reg_three_ramp_start = ramp_start[1];
	assign reg_four_ramp_start = ramp_start[2];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_write_two;
		access && pwrite && hit[0] && pstrb[0];
	endsequence
	sequence s_read_two;
		setup && !pwrite && hit[0] ##1 access;
	endsequence

	// the master leaves one idle cycle between a write and the next setup
	chk_reg_readback: assert property (s_write_two ##2 s_read_two // R8
		|-> prdata[7:1] == $past(pwdata[7:1], 3))
		else $error("written bits 7:1 not read back");
	chk_unmapped_err: assert property (access && hit == '0 // R8
		|-> pslverr && pready)
		else $error("unmapped access not flagged");
	chk_upper_zero: assert property (access && !pwrite // R8
		|-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	chk_reserved_inert: assert property ((s_write_two and ( // R8
		pwdata[lrc_pkg::LRC_BIT_RSVD] != ctrl[0][lrc_pkg::LRC_BIT_RSVD]
		&& pwdata[6:0] == {ctrl[0][6:5], pwdata[4], ctrl[0][3:0]}
		&& pin_rise == '0 && pin_fall == '0 && !seq_apply))
		|=> $stable(reg_two_on) && $stable(reg_two_target_second))
		else $error("reserved bit changed regulator behaviour");

	// a write without lane 0 leaves every register as it stood
	chk_strobe_blocks: assert property (access && pwrite && !pstrb[0] // R1
		&& !seq_apply && pin_rise == '0 && pin_fall == '0
		|=> $stable(ctrl))
		else $error("write without lane 0 strobe changed a register");
	// read data is the register as it stood in the setup cycle
	chk_read_capture: assert property (setup && !pwrite && hit[1] // R8
		|=> prdata[7:0] == $past(ctrl[1]))
		else $error("read data is not the register at setup");
	chk_unmapped_zero: assert property (setup && !pwrite && hit == '0 // R8
		|=> prdata == lrc_pkg::LRC_RDATA_IDLE)
		else $error("unmapped read did not return zero");
	chk_err_access: assert property (!access |-> !pslverr) // R8
		else $error("error flag raised outside access phase");
	chk_pulldown_four: assert property (##1 reg_four_pulldown_on // R2
		== (!reg_four_on && !ctrl[2][lrc_pkg::LRC_BIT_PD_OFF]))
		else $error("fourth pull-down does not follow its bits");

	// pin walks seen at the pins themselves, so a broken edge
	// detector cannot hide behind its own nets
	sequence s_first_rises;
		!gpio_first ##1 gpio_first;
	endsequence
	sequence s_first_falls;
		gpio_first ##1 !gpio_first;
	endsequence
	sequence s_thirteenth_falls;
		gpio_thirteenth ##1 !gpio_thirteenth;
	endsequence

	chk_pin_three_on: assert property ((s_first_rises ##0 // R5
		ctrl[1][lrc_pkg::LRC_FLD_EN_SEL +: 2]
		== lrc_pkg::LRC_SEL_PIN_FIRST) |=> reg_three_on)
		else $error("first pin rise did not switch third regulator on");
	chk_pin_three_off: assert property ((s_first_falls ##0 // R5
		ctrl[1][lrc_pkg::LRC_FLD_EN_SEL +: 2]
		== lrc_pkg::LRC_SEL_PIN_FIRST) |=> !reg_three_on)
		else $error("first pin fall did not switch third regulator off");
	chk_pin_two_second: assert property ((s_thirteenth_falls ##0 // R6
		ctrl[0][lrc_pkg::LRC_FLD_V_SEL +: 2]
		== lrc_pkg::LRC_SEL_PIN_THIRTEENTH) |=> reg_two_target_second)
		else $error("thirteenth pin fall did not pick second target");
endmodule : lrc_regs
`default_nettype wire

/* File: sim/lrc_regs_tb.sv */
// self-checking bench for the linear regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module lrc_regs_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] gp = 3'h0;
	logic seq_apply = 1'b0;
	logic [2:0] seq_tgt = 3'h0;
	logic [2:0] on;
	logic [2:0] pd;
	logic [2:0] tgt;
	logic [2:0] ramp;
	logic [2:0] seen = 3'h0;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int comparisons = 0;

	lrc_regs #(.ADDR_W(12)) u_lrc_regs (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gpio_first(gp[0]), .gpio_second(gp[1]), .gpio_thirteenth(gp[2]),
		.seq_apply(seq_apply), .seq_target_second(seq_tgt),
		.reg_two_on(on[0]), .reg_two_pulldown_on(pd[0]),
		.reg_two_target_second(tgt[0]), .reg_two_ramp_start(ramp[0]),
		.reg_three_on(on[1]), .reg_three_pulldown_on(pd[1]),
		.reg_three_target_second(tgt[1]), .reg_three_ramp_start(ramp[1]),
		.reg_four_on(on[2]), .reg_four_pulldown_on(pd[2]),
		.reg_four_target_second(tgt[2]), .reg_four_ramp_start(ramp[2])
	);

	initial begin
		forever #25 clock = ~clock;
	end

	function automatic logic [11:0] addr_of(input int i);
		return {2'h0, lrc_pkg::LRC_IDX_ALL[i], 2'h0};
	endfunction : addr_of

	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// entered just after a rising edge; leaves one idle edge after release
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	// ramp pulses last one cycle, so they are gathered at falling edges
	task automatic cyc(input int k);
		repeat (k) begin
			@(negedge clock);
			seen = seen | ramp;
			@(posedge clock);
		end
	endtask : cyc

	initial begin
		repeat (100000) @(posedge clock);
		failures++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, addr_of(i), 32'h0000_0000, 4'hf);
			check("reset value", {24'h0, lrc_pkg::LRC_CTRL_RESET}, rd);
		end
		check("pulldown at reset", 32'h0000_0007, 32'(pd));
		apb(1'b1, addr_of(0), 32'h0000_0011, 4'hf);
		apb(1'b0, addr_of(0), 32'h0000_0000, 4'hf);
		check("readback", 32'h0000_0011, rd);
		check("on and pulldown", 32'h0000_000e, 32'({on, pd}));
		apb(1'b1, addr_of(0), 32'h0000_0008, 4'hf);
		cyc(2);
		check("pulldown disabled", 32'h0000_0006, 32'({on, pd}));
		apb(1'b1, addr_of(0), 32'h0000_0018, 4'hf);
		cyc(2);
		check("reserved inert", 32'h0000_0006, 32'({on, pd}));
		// a write without its low byte strobe must leave the register alone
		apb(1'b1, addr_of(1), 32'h0000_0001, 4'h0);
		cyc(2);
		check("strobe off", 32'h0000_0000, 32'(on));
		apb(1'b0, 12'h0a8, 32'h0000_0000, 4'hf);
		check("unmapped err", 32'h0000_0001, 32'(err));
		check("unmapped data", 32'h0000_0000, rd);
		for (int c = 1; c < 4; c++) begin
			apb(1'b1, addr_of(1), 32'(c << 1), 4'hf);
			gp <= 3'(1 << (c - 1));
			cyc(4);
			check("pin on", 32'h0000_0002, 32'(on));
			gp <= 3'h0;
			cyc(4);
			check("pin off", 32'h0000_0000, 32'(on));
		end
		apb(1'b1, addr_of(1), 32'h0000_0000, 4'hf);
		gp <= 3'h7;
		cyc(4);
		check("pins ignored", 32'h0000_0000, 32'(on));
		gp <= 3'h0;
		cyc(4);
		apb(1'b1, addr_of(2), 32'h0000_0080, 4'hf);
		apb(1'b1, addr_of(1), 32'h0000_0082, 4'hf);
		seq_tgt <= 3'h6;
		seq_apply <= 1'b1;
		@(posedge clock);
		seq_apply <= 1'b0;
		cyc(3);
		check("sequencer run", 32'h0000_0026, 32'({on, tgt}));
		check("sequencer ramp", 32'h0000_0006, 32'(seen));
		for (int c = 1; c < 4; c++) begin
			apb(1'b1, addr_of(0), 32'(c << 5), 4'hf);
			gp <= 3'(1 << (c - 1));
			cyc(4);
			check("first target", 32'h0000_0000, 32'(tgt[0]));
			seen = 3'h0;
			gp <= 3'h0;
			cyc(4);
			check("second target", 32'h0000_0003, 32'({seen[0], tgt[0]}));
		end
		give_verdict();
	end
endmodule : lrc_regs_tb
`default_nettype wire
